// *** include/glob_ctrl_regs.svh ***
// Constants for the global reset, interrupt and clock-out block
`ifndef GLOB_CTRL_REGS_SVH
`define GLOB_CTRL_REGS_SVH

// Bit positions inside the written data byte
`define FRM_RST_BIT     1
`define ES_RST_BIT      2
`define HDLC_TX_RST_BIT 5
`define HDLC_RX_RST_BIT 6
`define BOC_RST_BIT     7

// Timing
`define CLK_KHZ         100000
`define CLK_PERIOD_NS   10
`define SETTLE_NS       300
`define SETTLE_CYC      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Prescaled reference rates in kHz
`define REF_T1_KHZ      16'h0608
`define REF_E1_KHZ      16'h0800

// Phase step of a 32-bit accumulator for a rate in kHz
`define AUX_INC(k) (32'(((64'(k)) << 32) / 64'(`CLK_KHZ)))

// Reset values
`define SYNC_RST_VAL    1'b1
`define ACC_RST_VAL     32'h0000_0000

`endif

// *** include/glob_ctrl_pkg.sv ***
// Types for the global reset, interrupt and clock-out block
package glob_ctrl_pkg;
    typedef logic [3:0] aux_sel_t;
    typedef enum logic [1:0] {
        CAT_TX     = 2'h0,
        CAT_RX     = 2'h1,
        CAT_LINE   = 2'h2,
        CAT_TESTER = 2'h3
    } irq_cat_t;
endpackage

// *** hw/glob_ctrl.sv ***
// Global clock-out, reset fan-out, line output control and interrupt tree
`timescale 1ns/1ps
`include "glob_ctrl_regs.svh"

// Notes on behaviour
// - Select code picks auxiliary clock frequency
// - Synthesizer references prescaled 1.544/2.048 MHz
// - Rate family bit picks T1 or E1 synthesizer
// - Hardware reset pin resets framers, lines, testers
// - Test port reset touches only scan logic
// - Soft reset write resets framers, lines, testers
// - Mode register bit 1 resets its framer
// - HDLC bits 6/5 reset rx/tx HDLC
// - Elastic control bit 2 resets its store
// - Bit-code control bit 7 resets controller
// - Code definition writes restart integration period
// - Power-down bits disable transmitter or receiver
// - Output enable low tristates outputs only
// - Global info shows pending ports for framer (Tx or Rx), line and tester
// - Info bits are real time, masked
// - Latched bits clear only on written ones, a pin or soft reset, or the sync reset
// - Masks gate info, never the latching
// - Interrupt pin is open-drain, active low
module glob_ctrl #(
    parameter int NP = 8,
    parameter int SW = 8
) (
    input  wire logic                   i_mclk,               // Master clock
    input  wire logic                   i_rst,                // Sync reset
    input  wire logic                   i_hw_reset_n,         // Reset pin
    input  wire logic                   i_test_port_reset_n,  // Scan reset pin
    input  wire glob_ctrl_pkg::aux_sel_t i_aux_clock_freq_sel, // Clock-out code
    input  wire logic                   i_line_rate_family_sel, // 1 = T1
    input  wire logic                   i_clk_cfg_wr,         // Clock config write
    input  wire logic [7:0]             i_wr_data,            // Write data
    input  wire logic                   i_soft_reset_wr,      // Soft reset write
    input  wire logic [NP-1:0]          i_rx_mode_wr,         // Rx mode write
    input  wire logic [NP-1:0]          i_tx_mode_wr,         // Tx mode write
    input  wire logic [NP-1:0]          i_rx_hdlc_wr,         // Rx HDLC write
    input  wire logic [NP-1:0]          i_tx_hdlc_wr,         // Tx HDLC write
    input  wire logic [NP-1:0]          i_rx_es_wr,           // Rx store write
    input  wire logic [NP-1:0]          i_tx_es_wr,           // Tx store write
    input  wire logic [NP-1:0]          i_rx_boc_wr,          // Bit-code write
    input  wire logic [NP-1:0]          i_code_def_wr,        // Code def write
    input  wire logic [NP-1:0]          i_tx_power_down,      // Tx power down
    input  wire logic [NP-1:0]          i_rx_power_down,      // Rx power down
    input  wire logic [NP-1:0]          i_line_out_enable,    // Output enable
    input  wire logic [NP-1:0]          i_line_pos,           // Pos line data
    input  wire logic [NP-1:0]          i_line_neg,           // Neg line data
    input  wire logic [3:0][NP-1:0][SW-1:0] i_evt,            // Status events
    input  wire logic [3:0][NP-1:0][SW-1:0] i_mask,           // Masks, 1 = off
    input  wire logic [3:0][NP-1:0]     i_clr_wr,             // Status clear write
    output logic                        o_aux_clock_out,      // Aux clock
    output logic                        o_synth_ref_clk,      // Scaled reference
    output logic                        o_aux_synth_t1,       // T1 synth in use
    output logic                        o_clk_settling,       // Clock settling
    output logic                        o_test_port_rst,      // Scan reset
    output logic [NP-1:0]               o_framer_rx_rst,      // Rx framer reset
    output logic [NP-1:0]               o_framer_tx_rst,      // Tx framer reset
    output logic [NP-1:0]               o_line_rst,           // Line reset
    output logic [NP-1:0]               o_tester_rst,         // Tester reset
    output logic [NP-1:0]               o_rx_hdlc_rst,        // Rx HDLC reset
    output logic [NP-1:0]               o_tx_hdlc_rst,        // Tx HDLC reset
    output logic [NP-1:0]               o_rx_es_rst,          // Rx store reset
    output logic [NP-1:0]               o_tx_es_rst,          // Tx store reset
    output logic [NP-1:0]               o_rx_boc_rst,         // Bit-code reset
    output logic [NP-1:0]               o_code_integ_restart, // Integration restart
    output logic [NP-1:0]               o_tx_powered,         // Transmitter on
    output logic [NP-1:0]               o_rx_powered,         // Receiver on
    output logic [NP-1:0]               o_line_out_pos,       // Pos output
    output logic [NP-1:0]               o_line_out_neg,       // Neg output
    output logic [NP-1:0]               o_line_out_oe,        // Output drive
    output logic [3:0][NP-1:0][SW-1:0]  o_latched,            // Latched status
    output logic [NP-1:0]               o_tx_irq_info,        // Tx info per port
    output logic [NP-1:0]               o_rx_irq_info,        // Rx info per port
    output logic [NP-1:0]               o_global_framer_irq_info, // Framer info
    output logic [NP-1:0]               o_global_line_irq_info,   // Line info
    output logic [NP-1:0]               o_global_tester_irq_info, // Tester info
    output logic                        o_irq_out_n,          // Interrupt level
    output logic                        o_irq_out_oe          // Interrupt drive
);

    function automatic logic pend(input logic [SW-1:0] lat, input logic [SW-1:0] msk);
        pend = |(lat & ~msk);
    endfunction

    function automatic logic [31:0] aux_inc(input glob_ctrl_pkg::aux_sel_t s);
        case (s)
            4'h0: aux_inc = `AUX_INC(16'h0800);
            4'h1: aux_inc = `AUX_INC(16'h1000);
            4'h2: aux_inc = `AUX_INC(16'h2000);
            4'h3: aux_inc = `AUX_INC(16'h4000);
            4'h4: aux_inc = `AUX_INC(16'h0608);
            4'h5: aux_inc = `AUX_INC(16'h0C10);
            4'h6: aux_inc = `AUX_INC(16'h1820);
            4'h7: aux_inc = `AUX_INC(16'h3040);
            4'h8: aux_inc = `AUX_INC(16'h0600);
            4'h9: aux_inc = `AUX_INC(16'h0C00);
            4'hA: aux_inc = `AUX_INC(16'h1800);
            4'hB: aux_inc = `AUX_INC(16'h3000);
            4'hC: aux_inc = `AUX_INC(16'h0020);
            4'hD: aux_inc = `AUX_INC(16'h0040);
            4'hE: aux_inc = `AUX_INC(16'h0080);
            default: aux_inc = `AUX_INC(16'h0100);
        endcase
    endfunction

    localparam int SCW = $clog2(`SETTLE_CYC + 1);

    // Pin synchronisers: a level counts once stages two and three agree
    logic [2:0] hw_s_q, hw_s_d, tp_s_q, tp_s_d;
    logic       hw_low_q, hw_low_d, tp_low_q, tp_low_d;

    always_comb begin
        hw_s_d   = {hw_s_q[1:0], i_hw_reset_n};
        tp_s_d   = {tp_s_q[1:0], i_test_port_reset_n};
        hw_low_d = (hw_s_q[1] == hw_s_q[2]) ? ~hw_s_q[2] : hw_low_q;
        tp_low_d = (tp_s_q[1] == tp_s_q[2]) ? ~tp_s_q[2] : tp_low_q;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            hw_s_q   <= {3{`SYNC_RST_VAL}};
            tp_s_q   <= {3{`SYNC_RST_VAL}};
            hw_low_q <= 1'b0;
            tp_low_q <= 1'b0;
        end else begin
            hw_s_q   <= hw_s_d;
            tp_s_q   <= tp_s_d;
            hw_low_q <= hw_low_d;
            tp_low_q <= tp_low_d;
        end
    end

    // Clock output: reference and aux synthesizers as phase accumulators
    logic [31:0] ref_acc_q, ref_acc_d, aux_acc_q, aux_acc_d;
    logic [31:0] ref_inc_q, ref_inc_d, aux_inc_q, aux_inc_d;
    logic        t1_q, t1_d, stl_q, stl_d;
    logic [SCW-1:0] settle_q, settle_d;

    always_comb begin
        t1_d      = i_line_rate_family_sel;
        ref_inc_d = t1_d ? `AUX_INC(`REF_T1_KHZ) : `AUX_INC(`REF_E1_KHZ);
        aux_inc_d = aux_inc(i_aux_clock_freq_sel);
        ref_acc_d = ref_acc_q + ref_inc_q;
        // Multiples re-anchor on each reference wrap; sub-reference codes never would, so run free
        aux_acc_d = (ref_acc_d < ref_acc_q && i_aux_clock_freq_sel[3:2] != 2'b11)
                  ? `ACC_RST_VAL : aux_acc_q + aux_inc_q;
        settle_d  = i_clk_cfg_wr ? SCW'(`SETTLE_CYC)
                  : (settle_q != '0) ? settle_q - 1'b1 : settle_q;
        stl_d     = (settle_d != '0);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ref_acc_q <= `ACC_RST_VAL;
            aux_acc_q <= `ACC_RST_VAL;
            ref_inc_q <= `AUX_INC(`REF_E1_KHZ);
            aux_inc_q <= `AUX_INC(16'h0800);
            t1_q      <= 1'b0;
            settle_q  <= '0;
            stl_q     <= 1'b0;
        end else begin
            ref_acc_q <= ref_acc_d;
            aux_acc_q <= aux_acc_d;
            ref_inc_q <= ref_inc_d;
            aux_inc_q <= aux_inc_d;
            t1_q      <= t1_d;
            settle_q  <= settle_d;
            stl_q     <= stl_d;
        end
    end

    assign o_aux_clock_out = aux_acc_q[31];
    assign o_synth_ref_clk = ref_acc_q[31];
    assign o_aux_synth_t1  = t1_q;
    assign o_clk_settling  = stl_q;

    // Reset fan-out, registered so each output is a flop
    logic          glob_rst;
    logic [NP-1:0] frx_d, ftx_d, lrst_d, trst_d, rh_d, th_d, res_d, tes_d, boc_d, cdi_d;
    logic [NP-1:0] frx_q, ftx_q, lrst_q, trst_q, rh_q, th_q, res_q, tes_q, boc_q, cdi_q;
    logic          tpr_q;

    always_comb begin
        glob_rst = hw_low_q | i_soft_reset_wr;
        lrst_d   = {NP{glob_rst}};
        trst_d   = {NP{glob_rst}};
        frx_d    = {NP{glob_rst}} | (i_rx_mode_wr & {NP{i_wr_data[`FRM_RST_BIT]}});
        ftx_d    = {NP{glob_rst}} | (i_tx_mode_wr & {NP{i_wr_data[`FRM_RST_BIT]}});
        rh_d     = i_rx_hdlc_wr & {NP{i_wr_data[`HDLC_RX_RST_BIT]}};
        th_d     = i_tx_hdlc_wr & {NP{i_wr_data[`HDLC_TX_RST_BIT]}};
        res_d    = i_rx_es_wr & {NP{i_wr_data[`ES_RST_BIT]}};
        tes_d    = i_tx_es_wr & {NP{i_wr_data[`ES_RST_BIT]}};
        boc_d    = i_rx_boc_wr & {NP{i_wr_data[`BOC_RST_BIT]}};
        cdi_d    = i_code_def_wr;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            frx_q  <= '1;
            ftx_q  <= '1;
            lrst_q <= '1;
            trst_q <= '1;
            rh_q   <= '0;
            th_q   <= '0;
            res_q  <= '0;
            tes_q  <= '0;
            boc_q  <= '0;
            cdi_q  <= '0;
            tpr_q  <= 1'b1;
        end else begin
            frx_q  <= frx_d;
            ftx_q  <= ftx_d;
            lrst_q <= lrst_d;
            trst_q <= trst_d;
            rh_q   <= rh_d;
            th_q   <= th_d;
            res_q  <= res_d;
            tes_q  <= tes_d;
            boc_q  <= boc_d;
            cdi_q  <= cdi_d;
            tpr_q  <= tp_low_q;
        end
    end

    assign o_framer_rx_rst      = frx_q;
    assign o_framer_tx_rst      = ftx_q;
    assign o_line_rst           = lrst_q;
    assign o_tester_rst         = trst_q;
    assign o_rx_hdlc_rst        = rh_q;
    assign o_tx_hdlc_rst        = th_q;
    assign o_rx_es_rst          = res_q;
    assign o_tx_es_rst          = tes_q;
    assign o_rx_boc_rst         = boc_q;
    assign o_code_integ_restart = cdi_q;
    assign o_test_port_rst      = tpr_q;

    // Line driver control; disabling output keeps the transmitter powered
    logic [NP-1:0] txp_q, txp_d, rxp_q, rxp_d, oe_q, oe_d, pos_q, neg_q;

    always_comb begin
        txp_d = ~i_tx_power_down;
        rxp_d = ~i_rx_power_down;
        oe_d  = txp_d & i_line_out_enable;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            txp_q <= '0;
            rxp_q <= '0;
            oe_q  <= '0;
            pos_q <= '0;
            neg_q <= '0;
        end else begin
            txp_q <= txp_d;
            rxp_q <= rxp_d;
            oe_q  <= oe_d;
            pos_q <= i_line_pos;
            neg_q <= i_line_neg;
        end
    end

    assign o_tx_powered   = txp_q;
    assign o_rx_powered   = rxp_q;
    assign o_line_out_oe  = oe_q;
    assign o_line_out_pos = pos_q;
    assign o_line_out_neg = neg_q;

    // Interrupt tree; info is built from next latched values so it is never stale
    logic [3:0][NP-1:0][SW-1:0] lat_q, lat_d;
    logic [3:0][NP-1:0]         inf_d, inf_q;
    logic                       irq_d, irq_q, irqn_d, irqn_q;
    logic [NP-1:0]              gfi_d, gfi_q;

    genvar gc, gp;
    generate
        for (gc = 0; gc < 4; gc++) begin : g_cat
            for (gp = 0; gp < NP; gp++) begin : g_port
                always_comb begin
                    // Event beats a same-cycle clear; zero bits in the write keep state
                    lat_d[gc][gp] = (lat_q[gc][gp] & ~({SW{i_clr_wr[gc][gp]}} & i_wr_data[SW-1:0]))
                                  | i_evt[gc][gp];
                    inf_d[gc][gp] = pend(lat_d[gc][gp], i_mask[gc][gp]);
                end
            end
        end
    endgenerate
    always_comb begin
        irq_d  = |inf_d;
        irqn_d = ~irq_d;
        gfi_d  = inf_d[glob_ctrl_pkg::CAT_TX] | inf_d[glob_ctrl_pkg::CAT_RX];
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst | glob_rst) begin
            lat_q  <= '0;
            inf_q  <= '0;
            irq_q  <= 1'b0;
            irqn_q <= 1'b1;
            gfi_q  <= '0;
        end else begin
            lat_q  <= lat_d;
            inf_q  <= inf_d;
            irq_q  <= irq_d;
            irqn_q <= irqn_d;
            gfi_q  <= gfi_d;
        end
    end

    assign o_latched                = lat_q;
    assign o_tx_irq_info            = inf_q[glob_ctrl_pkg::CAT_TX];
    assign o_rx_irq_info            = inf_q[glob_ctrl_pkg::CAT_RX];
    assign o_global_framer_irq_info = gfi_q;
    assign o_global_line_irq_info   = inf_q[glob_ctrl_pkg::CAT_LINE];
    assign o_global_tester_irq_info = inf_q[glob_ctrl_pkg::CAT_TESTER];
    // Open drain: drive low only while pending
    assign o_irq_out_n              = irqn_q;
    assign o_irq_out_oe             = irq_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    aux_code_a: assert property ((i_aux_clock_freq_sel == 4'hC)[*2]
        |-> aux_inc_q == `AUX_INC(16'h0020)) else $error("aux step wrong");
    ref_rate_a: assert property (##1 o_aux_synth_t1 == $past(i_line_rate_family_sel)
        && ref_inc_q == (o_aux_synth_t1 ? `AUX_INC(`REF_T1_KHZ)
        : `AUX_INC(`REF_E1_KHZ))) else $error("reference rate wrong");
    hw_reset_a: assert property ((!i_hw_reset_n)[*6]
        |-> &o_framer_rx_rst && &o_line_rst && &o_tester_rst) else $error("pin reset lost");
    test_rst_a: assert property ((!i_test_port_reset_n && i_hw_reset_n)[*6]
        |-> o_test_port_rst) else $error("scan reset lost");
    soft_reset_a: assert property (i_soft_reset_wr
        |=> &o_framer_tx_rst && &o_line_rst && &o_tester_rst) else $error("soft reset");
    frm_reset_a: assert property (i_rx_mode_wr[0] && i_wr_data[1]
        |=> o_framer_rx_rst[0]) else $error("framer reset");
    hdlc_reset_a: assert property (i_tx_hdlc_wr[0] && i_wr_data[5]
        |=> o_tx_hdlc_rst[0] ##1 !o_tx_hdlc_rst[0] || $past(i_tx_hdlc_wr[0])) else $error("hdlc");
    es_reset_a: assert property (o_rx_es_rst[0]
        |-> $past(i_rx_es_wr[0]) && $past(i_wr_data[2])) else $error("store reset");
    boc_reset_a: assert property (i_rx_boc_wr[0] && i_wr_data[7]
        |=> o_rx_boc_rst[0]) else $error("bit-code reset");
    code_restart_a: assert property (i_code_def_wr[0]
        |=> o_code_integ_restart[0]) else $error("integration restart");
    line_oe_a: assert property (o_line_out_oe[0]
        |-> o_tx_powered[0] && $past(i_line_out_enable[0])) else $error("line drive");
    latch_set_a: assert property (i_evt[1][0][0] && !glob_rst
        |=> o_latched[1][0][0]) else $error("event lost");
    latch_clr_a: assert property (o_latched[2][0][0] && !i_evt[2][0][0] && !glob_rst
        && !(i_clr_wr[2][0] && i_wr_data[0])
        |=> o_latched[2][0][0]) else $error("cleared without a one");
    info_live_a: assert property (##1 o_tx_irq_info[0]
        == pend(o_latched[0][0], $past(i_mask[0][0]))) else $error("info stale");
    info_glob_a: assert property (o_global_framer_irq_info[1]
        == (o_tx_irq_info[1] | o_rx_irq_info[1])) else $error("framer info");
    irq_or_a: assert property (o_irq_out_n == !(|{o_global_framer_irq_info,
        o_global_line_irq_info, o_global_tester_irq_info})) else $error("irq level");
    settle_len_a: assert property (i_clk_cfg_wr ##1 !i_clk_cfg_wr[*8]
        |-> o_clk_settling) else $error("settle short");

    irq_seen_c: cover property ($fell(o_irq_out_n) ##[1:20] $rose(o_irq_out_n));
    soft_rst_c: cover property (i_soft_reset_wr);
    set_clear_c: cover property (i_evt[0][0][0] && i_clr_wr[0][0] && i_wr_data[0]);
endmodule

// *** verif/irq_host_model.sv ***
// Host-side model of the interrupt wire with its board pull-up
`timescale 1ns/1ps
module irq_host_model (
    input  wire logic i_mclk,       // Master clock
    input  wire logic i_irq_out_n,  // Device interrupt level
    input  wire logic i_irq_out_oe, // Device pulls the wire
    output logic      o_irq_wire,   // Resolved wire level
    output int        o_irq_count   // Falling edges seen
);
    logic prev_q = 1'b1;
    int   count_q = 0;
    // Only the device can pull low; the pull-up restores high otherwise
    assign o_irq_wire = (i_irq_out_oe && !i_irq_out_n) ? 1'b0 : 1'b1;
    assign o_irq_count = count_q;
    always @(posedge i_mclk) begin
        if (prev_q && !o_irq_wire) begin
            count_q <= count_q + 1;
        end
        prev_q <= o_irq_wire;
    end
endmodule

// *** verif/global_reset_irq_clockout_bench.sv ***
// Self-checking bench for reset fan-out, line control, interrupts and clock-out
`timescale 1ns/1ps
module global_reset_irq_clockout_bench;
    localparam int NP = 8;
    localparam int SW = 8;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       hw_n = 1'b1, tp_n = 1'b1, fam = 1'b0;
    logic                       cfg_wr = 1'b0, sr_wr = 1'b0;
    logic [7:0]                 wd = 8'h00;
    glob_ctrl_pkg::aux_sel_t    sel = 4'h0;
    logic [NP-1:0]              wv [8];
    logic [NP-1:0]              rs [8];
    logic [NP-1:0]              tpd = '0, rpd = '0, ten = '1, lp = '0;
    logic [3:0][NP-1:0][SW-1:0] evt = '0, msk = '0, lat;
    logic [3:0][NP-1:0]         clr = '0;
    logic [NP-1:0]              lrst, trst, txp, rxp, oe, gf, gl, gt, lpo, lno, ti, ri;
    logic                       aux, refc, t1, settle, tpr, irq_n, irq_oe, irq_w;
    int                         irq_cnt, n, na, nr, bad_count = 0, comparisons = 0;
    int bp [8] = '{1, 1, 6, 5, 2, 2, 7, 0};
    int khz [16] = '{2048, 4096, 8192, 16384, 1544, 3088, 6176, 12352,
                     1536, 3072, 6144, 12288, 32, 64, 128, 256};

    glob_ctrl #(.NP(NP), .SW(SW)) DUT (
        .i_mclk(clk), .i_rst(rst), .i_hw_reset_n(hw_n), .i_test_port_reset_n(tp_n),
        .i_aux_clock_freq_sel(sel), .i_line_rate_family_sel(fam), .i_clk_cfg_wr(cfg_wr),
        .i_wr_data(wd), .i_soft_reset_wr(sr_wr), .i_rx_mode_wr(wv[0]), .i_tx_mode_wr(wv[1]),
        .i_rx_hdlc_wr(wv[2]), .i_tx_hdlc_wr(wv[3]), .i_rx_es_wr(wv[4]), .i_tx_es_wr(wv[5]),
        .i_rx_boc_wr(wv[6]), .i_code_def_wr(wv[7]), .i_tx_power_down(tpd),
        .i_rx_power_down(rpd), .i_line_out_enable(ten), .i_line_pos(lp), .i_line_neg(~lp),
        .i_evt(evt), .i_mask(msk), .i_clr_wr(clr), .o_aux_clock_out(aux),
        .o_synth_ref_clk(refc), .o_aux_synth_t1(t1), .o_clk_settling(settle),
        .o_test_port_rst(tpr), .o_framer_rx_rst(rs[0]), .o_framer_tx_rst(rs[1]),
        .o_line_rst(lrst), .o_tester_rst(trst), .o_rx_hdlc_rst(rs[2]), .o_tx_hdlc_rst(rs[3]),
        .o_rx_es_rst(rs[4]), .o_tx_es_rst(rs[5]), .o_rx_boc_rst(rs[6]),
        .o_code_integ_restart(rs[7]), .o_tx_powered(txp), .o_rx_powered(rxp),
        .o_line_out_pos(lpo), .o_line_out_neg(lno), .o_line_out_oe(oe), .o_latched(lat),
        .o_tx_irq_info(ti), .o_rx_irq_info(ri), .o_global_framer_irq_info(gf),
        .o_global_line_irq_info(gl), .o_global_tester_irq_info(gt),
        .o_irq_out_n(irq_n), .o_irq_out_oe(irq_oe)
    );

    irq_host_model HOST (
        .i_mclk(clk), .i_irq_out_n(irq_n), .i_irq_out_oe(irq_oe),
        .o_irq_wire(irq_w), .o_irq_count(irq_cnt)
    );

    always #5 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic give_verdict;
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Strobe and clear both leave the bench just after the taking edge
    task automatic write(input int k, input int p, input logic [7:0] d);
        wv[k][p] = 1'b1;
        wd = d;
        cyc(1);
        wv[k] = '0;
    endtask

    task automatic clear(input int c, input logic [7:0] d);
        clr[c][c+1] = 1'b1;
        wd = d;
        cyc(1);
        clr = '0;
    endtask

    function automatic logic [NP-1:0] ginfo(input int c);
        return (c < 2) ? gf : (c == 2) ? gl : gt;
    endfunction

    task automatic count_edges;
        logic pa, pr;
        na = 0;
        nr = 0;
        pa = aux;
        pr = refc;
        repeat (2000) begin
            cyc(1);
            na += int'(aux && !pa);
            nr += int'(refc && !pr);
            pa = aux;
            pr = refc;
        end
    endtask

    initial begin
        #500_000;
        bad_count++;
        give_verdict();
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            wv[k] = '0;
        end
        cyc(6);
        rst = 1'b0;
        cyc(1);
        check(|lat, 1'b0);
        check(irq_w, 1'b1);
        // Host bring-up: clock setup first, then zero fill with mode registers first
        fam = 1'b1;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(30);
        check(settle, 1'b0);
        wd = 8'h71;
        cyc(1);
        for (int k = 0; k < 8; k++) begin
            write(k, 0, 8'h00);
            check(rs[k], (k == 7) ? 8'h01 : 8'h00);
            cyc(1);
        end
        for (int k = 0; k < 8; k++) begin
            for (int p = 0; p < NP; p += 7) begin
                write(k, p, 8'h01 << bp[k]);
                check(rs[k], 8'h01 << p);
                cyc(1);
                check(rs[k], 8'h00);
                write(k, p, ~(8'h01 << bp[k]));
                check(rs[k], (k == 7) ? 8'h01 << p : 8'h00);
                cyc(1);
            end
        end
        sr_wr = 1'b1;
        cyc(1);
        sr_wr = 1'b0;
        check({rs[0], rs[1], lrst, trst, rs[2]}, {{4{8'hFF}}, 8'h00});
        tpd = 8'h04;
        rpd = 8'h20;
        ten = 8'hF7;
        lp = 8'h5A;
        cyc(2);
        check({txp, rxp, oe, lpo, lno}, {8'hFB, 8'hDF, 8'hF3, 8'h5A, 8'hA5});
        tpd = '0;
        rpd = '0;
        ten = '1;
        cyc(2);
        check({txp, rxp, oe}, {3{8'hFF}});
        for (int c = 0; c < 4; c++) begin
            evt[c][c+1][3] = 1'b1;
            cyc(1);
            evt = '0;
            check({lat[c][c+1], irq_w, ginfo(c)}, {8'h08, 1'b0, 8'h01 << (c + 1)});
            check({ti, ri}, {(c == 0) ? 8'h02 : 8'h00, (c == 1) ? 8'h04 : 8'h00});
            clear(c, 8'h00);
            check(lat[c][c+1], 8'h08);
            cyc(1);
            clear(c, 8'h08);
            check({lat[c][c+1], irq_w, ginfo(c)}, {8'h00, 1'b1, 8'h00});
            msk[c][c+1][3] = 1'b1;
            cyc(1);
            evt[c][c+1][3] = 1'b1;
            cyc(1);
            evt = '0;
            check({lat[c][c+1], irq_w, ginfo(c)}, {8'h08, 1'b1, 8'h00});
            msk = '0;
            cyc(2);
            check({irq_w, ginfo(c)}, {1'b0, 8'h01 << (c + 1)});
            clear(c, 8'h08);
            check(irq_w, 1'b1);
            cyc(1);
        end
        check(irq_cnt, 8);
        hw_n = 1'b0;
        n = 0;
        while (lrst !== '1 && n < 8) begin
            cyc(1);
            n++;
        end
        check(n, 5);
        cyc(2);
        check({rs[0], rs[1], lrst, trst}, {4{8'hFF}});
        hw_n = 1'b1;
        cyc(12);
        tp_n = 1'b0;
        cyc(6);
        check({tpr, lrst, rs[0]}, {1'b1, 16'h0000});
        tp_n = 1'b1;
        cyc(6);
        check(tpr, 1'b0);
        fam = 1'b1;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        n = 0;
        // The bench keeps off the clock setup until the settle window ends
        while (settle === 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        check(n, 30);
        for (int s = 0; s < 16; s++) begin
            sel = 4'(s);
            fam = (s < 8) ? s[2] : (s < 12);
            cyc(50);
            check(t1, fam);
            count_edges();
            check((na - khz[s] / 50) ** 2 <= (khz[s] / 1250 + 2) ** 2, 1'b1);
            check(nr >= (fam ? 29 : 39) && nr <= (fam ? 32 : 42), 1'b1);
        end
        give_verdict();
    end
endmodule
